/* rtl/adc_seq_pkg.sv */
// Package: register map, field positions, reset values and timing of the conversion sequencer
package adc_seq_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_PORTCFG  = 8'h04;
  localparam logic [7:0] OFS_RESULT   = 8'h08;
  localparam logic [7:0] OFS_PORTDATA = 8'h0C;
  localparam logic [7:0] OFS_DIR      = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_MASK     = 8'h18;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int POS_POWER  = 0;
  localparam int POS_GO     = 2;
  localparam int POS_CHAN   = 3;
  localparam int POS_CLKSEL = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [2:0] RST_PORTCFG = 3'h0;
  localparam logic [7:0] RST_RESULT  = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'hFF;
  localparam logic [0:0] RST_MASK    = 1'h0;

  // ---------------------------------------------------------------
  // Clock select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CLK_DIV2  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC    = 2'h3;

  // ---------------------------------------------------------------
  // Timing: bit periods in clock cycles or ns, conversion and wait lengths in half bit periods
  // ---------------------------------------------------------------
  localparam int DIV2_CYCLES   = 2;
  localparam int DIV8_CYCLES   = 8;
  localparam int DIV32_CYCLES  = 32;
  localparam int RC_PERIOD_NS  = 4000;
  localparam int CLOCK_NS      = 100;
  localparam int RC_CYCLES     = RC_PERIOD_NS / CLOCK_NS;
  localparam logic [4:0] CONV_HALVES = 5'h13;
  localparam logic [4:0] WAIT_HALVES = 5'h04;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_t;

endpackage : adc_seq_pkg

/* rtl/adc_conversion_sequencer.sv */
// Conversion sequencer of an 8-bit successive-approximation converter with APB registers
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PIN_LEVEL,
  input  wire logic [7:0]  SAR_CODE,
  output logic      [2:0]  SAMPLE_CHANNEL,
  output logic             HOLD_CONNECT,
  output logic             IRQ
);

  // ---------------------------------------------------------------
  // Pin and SAR code synchroniser
  // ---------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] sar_meta;
  logic [7:0] sar_sync;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      sar_meta <= 8'h00;
      sar_sync <= 8'h00;
    end else begin
      pin_meta <= PIN_LEVEL;
      pin_sync <= pin_meta;
      sar_meta <= SAR_CODE;
      sar_sync <= sar_meta;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [1:0]  conv_clock_select;
  logic [2:0]  input_channel_select;
  logic        go_flag;
  logic        converter_power_on;
  logic [2:0]  port_config_reg;
  logic [7:0]  conv_result_reg;
  logic [7:0]  pin_direction_bits;
  logic        conv_done_flag;
  logic        done_mask;
  logic [5:0]  div_count;
  logic [4:0]  half_count;
  logic        hold_connect;
  seq_state_t  state;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;

  logic [1:0]  next_conv_clock_select;
  logic [2:0]  next_input_channel_select;
  logic        next_go_flag;
  logic        next_converter_power_on;
  logic [2:0]  next_port_config_reg;
  logic [7:0]  next_conv_result_reg;
  logic [7:0]  next_pin_direction_bits;
  logic        next_conv_done_flag;
  logic        next_done_mask;
  logic [5:0]  next_div_count;
  logic [4:0]  next_half_count;
  logic        next_hold_connect;
  seq_state_t  next_state;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic       wr_access;
  logic       rd_setup;
  logic [5:0] div_limit;
  logic       tick;
  logic [7:0] analog_pins;
  logic       mapped;

  always_comb begin
    case (conv_clock_select)
      CLK_DIV2:  div_limit = 6'(DIV2_CYCLES / 2 - 1);
      CLK_DIV8:  div_limit = 6'(DIV8_CYCLES / 2 - 1);
      CLK_DIV32: div_limit = 6'(DIV32_CYCLES / 2 - 1);
      default:   div_limit = 6'(RC_CYCLES / 2 - 1);
    endcase
  end

  assign tick      = (div_count == div_limit);
  assign wr_access = PSEL && PENABLE && PWRITE && pready;
  assign rd_setup  = PSEL && !PENABLE && !PWRITE;
  assign mapped    = (PADDR == OFS_CONTROL) || (PADDR == OFS_PORTCFG) || (PADDR == OFS_RESULT) ||
                     (PADDR == OFS_PORTDATA) || (PADDR == OFS_DIR) || (PADDR == OFS_STATUS) ||
                     (PADDR == OFS_MASK);

  // ---------------------------------------------------------------
  // Analog pin map
  // ---------------------------------------------------------------

  always_comb begin
    case (port_config_reg)
      3'h0:    analog_pins = 8'hFF;
      3'h1:    analog_pins = 8'hF7;
      3'h2:    analog_pins = 8'h1F;
      3'h3:    analog_pins = 8'h37;
      3'h4:    analog_pins = 8'h0B;
      3'h5:    analog_pins = 8'h03;
      default: analog_pins = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_conv_clock_select    = conv_clock_select;
    next_input_channel_select = input_channel_select;
    next_go_flag              = go_flag;
    next_converter_power_on   = converter_power_on;
    next_port_config_reg      = port_config_reg;
    next_conv_result_reg      = conv_result_reg;
    next_pin_direction_bits   = pin_direction_bits;
    next_conv_done_flag       = conv_done_flag;
    next_done_mask            = done_mask;
    next_div_count            = tick ? 6'h00 : div_count + 6'h01;
    next_half_count           = half_count;
    next_hold_connect         = hold_connect;
    next_state                = state;
    next_prdata               = prdata;
    next_pready               = PSEL && !PENABLE;
    next_pslverr              = PSEL && !PENABLE && !mapped;

    if (rd_setup) begin
      case (PADDR)
        OFS_CONTROL:  next_prdata = {24'h000000, conv_clock_select, input_channel_select,
                                     go_flag, 1'b0, converter_power_on};
        OFS_PORTCFG:  next_prdata = {29'h00000000, port_config_reg};
        OFS_RESULT:   next_prdata = {24'h000000, conv_result_reg};
        OFS_PORTDATA: next_prdata = {24'h000000, pin_sync & ~analog_pins};
        OFS_DIR:      next_prdata = {24'h000000, pin_direction_bits};
        OFS_STATUS:   next_prdata = {31'h00000000, conv_done_flag};
        OFS_MASK:     next_prdata = {31'h00000000, done_mask};
        default:      next_prdata = 32'h00000000;
      endcase
    end

    if (PSEL && !PENABLE && !mapped) begin
      next_prdata = 32'h00000000;
    end

    if (wr_access) begin
      case (PADDR)
        OFS_CONTROL: begin
          next_conv_clock_select    = PWDATA[POS_CLKSEL +: 2];
          next_input_channel_select = PWDATA[POS_CHAN +: 3];
          next_converter_power_on   = PWDATA[POS_POWER];
          next_go_flag              = PWDATA[POS_GO] && PWDATA[POS_POWER];
        end
        OFS_PORTCFG: next_port_config_reg    = PWDATA[2:0];
        OFS_RESULT:  next_conv_result_reg    = PWDATA[7:0];
        OFS_DIR:     next_pin_direction_bits = PWDATA[7:0];
        OFS_STATUS:  next_conv_done_flag     = conv_done_flag && !PWDATA[0];
        OFS_MASK:    next_done_mask          = PWDATA[0];
        default:     next_done_mask          = done_mask;
      endcase
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    case (state)
      ST_IDLE: begin
        if (go_flag && converter_power_on) begin
          next_state        = ST_CONV;
          next_half_count   = 5'h00;
          next_div_count    = 6'h00;
          next_hold_connect = 1'b0;
        end
      end
      ST_CONV: begin
        if (!go_flag || !converter_power_on) begin
          next_state      = ST_WAIT;
          next_half_count = 5'h00;
          next_div_count  = 6'h00;
        end else if (tick) begin
          if (half_count == CONV_HALVES - 5'h01) begin
            next_conv_result_reg = sar_sync;
            next_go_flag         = 1'b0;
            next_conv_done_flag  = 1'b1;
            next_state           = ST_WAIT;
            next_half_count      = 5'h00;
          end else begin
            next_half_count = half_count + 5'h01;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (half_count == WAIT_HALVES - 5'h01) begin
            next_state        = ST_IDLE;
            next_hold_connect = converter_power_on;
          end else begin
            next_half_count = half_count + 5'h01;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase

    // ---------------------------------------------------------------
    // Holding capacitor connection
    // ---------------------------------------------------------------
    if (state == ST_IDLE && !converter_power_on) begin
      next_hold_connect = 1'b0;
    end else if (state == ST_IDLE && converter_power_on && !go_flag) begin
      next_hold_connect = 1'b1;
    end

    next_irq = next_conv_done_flag && next_done_mask;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      conv_clock_select    <= RST_CONTROL[POS_CLKSEL +: 2];
      input_channel_select <= RST_CONTROL[POS_CHAN +: 3];
      go_flag              <= RST_CONTROL[POS_GO];
      converter_power_on   <= RST_CONTROL[POS_POWER];
      port_config_reg      <= RST_PORTCFG;
      conv_result_reg      <= RST_RESULT;
      pin_direction_bits   <= RST_DIR;
      conv_done_flag       <= 1'b0;
      done_mask            <= RST_MASK[0];
      div_count            <= 6'h00;
      half_count           <= 5'h00;
      hold_connect         <= 1'b0;
      state                <= ST_IDLE;
      prdata               <= 32'h00000000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      conv_clock_select    <= next_conv_clock_select;
      input_channel_select <= next_input_channel_select;
      go_flag              <= next_go_flag;
      converter_power_on   <= next_converter_power_on;
      port_config_reg      <= next_port_config_reg;
      conv_result_reg      <= next_conv_result_reg;
      pin_direction_bits   <= next_pin_direction_bits;
      conv_done_flag       <= next_conv_done_flag;
      done_mask            <= next_done_mask;
      div_count            <= next_div_count;
      half_count           <= next_half_count;
      hold_connect         <= next_hold_connect;
      state                <= next_state;
      prdata               <= next_prdata;
      pready               <= next_pready;
      pslverr              <= next_pslverr;
      irq                  <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign PRDATA         = prdata;
  assign PREADY         = pready;
  assign PSLVERR        = pslverr;
  assign SAMPLE_CHANNEL = input_channel_select;
  assign HOLD_CONNECT   = hold_connect;
  assign IRQ            = irq;

endmodule : adc_conversion_sequencer

/* dv/adc_seq_sva.sv */
// Checker: bus and sequencing assertions of the conversion sequencer
`timescale 1ns/1ps
module adc_seq_sva
  import adc_seq_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [2:0]  SAMPLE_CHANNEL,
  input wire logic        HOLD_CONNECT,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_write(logic [7:0] a);
    PSEL && PENABLE && PREADY && PWRITE && PADDR == a;
  endsequence
  property p_ready_next;
    s_setup |=> PREADY;
  endproperty
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  property p_ready_idle;
    !PSEL |=> !PREADY;
  endproperty
  property p_err_ready;
    PSLVERR |-> PREADY && PRDATA == 32'h0;
  endproperty
  property p_err_only_unmapped;
    PREADY && PADDR <= OFS_MASK && PADDR[1:0] == 2'h0 |-> !PSLVERR;
  endproperty
  property p_hold_drop;
    s_write(OFS_CONTROL) and (PWDATA[POS_GO] && PWDATA[POS_POWER]) |-> ##[1:2] !HOLD_CONNECT;
  endproperty
  property p_hold_min;
    $fell(HOLD_CONNECT) |-> !HOLD_CONNECT [*4];
  endproperty
  property p_irq_mask;
    s_write(OFS_MASK) and !PWDATA[0] |-> ##2 !IRQ;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready missing after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_ready_idle: assert property (p_ready_idle) else $error("ready without select");
  a_err_ready: assert property (p_err_ready) else $error("error without ready or with data");
  a_err_only_unmapped: assert property (p_err_only_unmapped) else $error("error on mapped register");
  a_hold_drop: assert property (p_hold_drop) else $error("capacitor still connected");
  a_hold_min: assert property (p_hold_min) else $error("capacitor reconnected too soon");
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
endmodule : adc_seq_sva

/* dv/analog_front_end.sv */
// Analog front end model: pin levels and held sample code
`timescale 1ns/1ps
module analog_front_end (
  input  wire logic [2:0] sample_channel,
  input  wire logic       hold_connect,
  output logic      [7:0] pin_level,
  output logic      [7:0] sar_code
);
  logic [7:0] held = 8'h00;
  assign pin_level = 8'hFF;
  // Capacitor keeps its level while disconnected
  always @(hold_connect or sample_channel) if (hold_connect) held = 8'h5A + 8'h13 * sample_channel;
  assign sar_code = held;
endmodule : analog_front_end

/* dv/tb.sv */
// Testbench: conversions, port reads, abort and interrupt of the sequencer
`timescale 1ns/1ps
module tb;
  import adc_seq_pkg::*;
  typedef struct {logic [1:0] sel; logic [2:0] ch; logic [2:0] cfg; logic [7:0] port; int h;} row_t;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, hold_connect, irq, er;
  logic [7:0]  paddr, pin_level, sar_code;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  sample_channel;
  int          err_total, samples_checked, cyc, n;
  row_t rows [4] = '{'{CLK_DIV2, 3'h7, 3'h0, 8'h00, DIV2_CYCLES / 2}, '{CLK_DIV8, 3'h0, 3'h1, 8'h08, DIV8_CYCLES / 2},
    '{CLK_DIV32, 3'h3, 3'h2, 8'hE0, DIV32_CYCLES / 2}, '{CLK_RC, 3'h5, 3'h6, 8'hFF, RC_CYCLES / 2}};
  adc_conversion_sequencer adc_conversion_sequencer_inst (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_LEVEL(pin_level), .SAR_CODE(sar_code), .SAMPLE_CHANNEL(sample_channel),
    .HOLD_CONNECT(hold_connect), .IRQ(irq));
  analog_front_end analog_front_end_inst (.sample_channel(sample_channel), .hold_connect(hold_connect),
    .pin_level(pin_level), .sar_code(sar_code));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task cnt(input bit use_irq);
    n = 0;
    while ((use_irq ? irq : hold_connect) !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask : cnt
  task summarize;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    err_total = 0; samples_checked = 0; cyc = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk("control", OFS_CONTROL, RST_CONTROL);
    rdchk("portcfg", OFS_PORTCFG, RST_PORTCFG);
    rdchk("result", OFS_RESULT, RST_RESULT);
    rdchk("dir", OFS_DIR, RST_DIR);
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("mask", OFS_MASK, RST_MASK);
    rdchk("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'h1, er);
    apb(1'b1, OFS_DIR, 32'h0);
    apb(1'b1, OFS_MASK, 32'h1);
    foreach (rows[i]) begin
      apb(1'b1, OFS_PORTCFG, rows[i].cfg);
      rdchk("portdata", OFS_PORTDATA, rows[i].port);
      apb(1'b1, OFS_CONTROL, {rows[i].sel, rows[i].ch, 3'h1});
      cnt(1'b0);
      apb(1'b1, OFS_CONTROL, {rows[i].sel, rows[i].ch, 3'h5});
      cnt(1'b1);
      chk("channel", rows[i].ch, sample_channel);
      chk("conv time", 32'h1, n >= 19 * rows[i].h && n <= 19 * rows[i].h + 4);
      cnt(1'b0);
      chk("wait time", 32'h1, n >= 4 * rows[i].h - 2 && n <= 4 * rows[i].h + 4);
      rdchk("result", OFS_RESULT, 8'h5A + 8'h13 * rows[i].ch);
      rdchk("control", OFS_CONTROL, {rows[i].sel, rows[i].ch, 3'h1});
      rdchk("status", OFS_STATUS, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h1);
      repeat (2) @(posedge clock);
      chk("irq", 32'h0, irq);
    end
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    chk("slverr write", 32'h1, er);
    chk("error data", 32'h0, rd);
    apb(1'b1, OFS_RESULT, 32'h77);
    apb(1'b1, OFS_CONTROL, {CLK_DIV32, 3'h2, 3'h5});
    repeat (20) @(posedge clock);
    apb(1'b1, OFS_CONTROL, {CLK_DIV32, 3'h2, 3'h1});
    cnt(1'b0);
    chk("abort wait", 32'h1, n >= 4 * 16 - 2 && n <= 4 * 16 + 4);
    chk("channel", 32'h2, sample_channel);
    rdchk("result", OFS_RESULT, 32'h77);
    rdchk("status", OFS_STATUS, 32'h0);
    apb(1'b1, OFS_MASK, 32'h0);
    apb(1'b1, OFS_CONTROL, {CLK_DIV32, 3'h1, 3'h5});
    repeat (3) @(posedge clock);
    chk("hold low", 32'h0, hold_connect);
    cnt(1'b0);
    chk("masked irq", 32'h0, irq);
    rdchk("status", OFS_STATUS, 32'h1);
    apb(1'b1, OFS_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("unmasked irq", 32'h1, irq);
    apb(1'b1, OFS_CONTROL, {CLK_DIV32, 3'h4, 3'h5});
    repeat (3) @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    chk("reset irq", 32'h0, irq);
    chk("reset hold", 32'h0, hold_connect);
    chk("reset channel", RST_CONTROL[POS_CHAN +: 3], sample_channel);
    sys_rst <= 1'b0;
    rdchk("control", OFS_CONTROL, RST_CONTROL);
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("mask", OFS_MASK, RST_MASK);
    summarize();
  end
endmodule : tb
bind adc_conversion_sequencer adc_seq_sva adc_seq_sva_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SAMPLE_CHANNEL(SAMPLE_CHANNEL), .HOLD_CONNECT(HOLD_CONNECT), .IRQ(IRQ));
